/* File: include/snvs_params.svh */
`ifndef SNVS_PARAMS_SVH
`define SNVS_PARAMS_SVH

// clock and link timing
`define SNVS_MCLK_NS      8
`define SNVS_STORE_MS     5
`define SNVS_STORE_CYC    ((`SNVS_STORE_MS * 1000000) / `SNVS_MCLK_NS)
`define SNVS_RECALL_NS    2000
`define SNVS_RECALL_CYC   (`SNVS_RECALL_NS / `SNVS_MCLK_NS)
`define SNVS_PUR_NS       2000
`define SNVS_PUR_CYC      (`SNVS_PUR_NS / `SNVS_MCLK_NS)
`define SNVS_PUR_WAIT_CYC (`SNVS_PUR_CYC + 8)
`define SNVS_SCLK_HALF_NS  80
`define SNVS_SCLK_HALF_CYC ((`SNVS_SCLK_HALF_NS + `SNVS_MCLK_NS - 1) / `SNVS_MCLK_NS)
`define SNVS_TMR_W        20

// instruction fields
`define SNVS_INS_START    7
`define SNVS_ADR_MSB      6
`define SNVS_ADR_LSB      3
`define SNVS_OP_MSB       2
`define SNVS_INS_BITS     8
`define SNVS_WORD_BITS    16
`define SNVS_XFER_BITS    24

// controller registers, byte offsets
`define SNVS_REG_CMD      8'h00
`define SNVS_REG_WDATA    8'h04
`define SNVS_REG_RDATA    8'h08
`define SNVS_REG_STAT     8'h0c
`define SNVS_REG_PINS     8'h10
`define SNVS_STAT_BUSY    0
`define SNVS_STAT_PUR     1
`define SNVS_PINS_STORE   0
`define SNVS_PINS_RECALL  1

// reset values
`define SNVS_WEL_RST      1'b0
`define SNVS_PRL_RST      1'b0

`endif

/* File: include/snvs_pkg.sv */
`default_nettype none

package snvs_pkg;

   typedef enum logic [2:0] {
      SNVS_OP_WRDIS  = 3'h0,
      SNVS_OP_COMMIT = 3'h1,
      SNVS_OP_RSVD   = 3'h2,
      SNVS_OP_WRITE  = 3'h3,
      SNVS_OP_WRSET  = 3'h4,
      SNVS_OP_RELOAD = 3'h5,
      SNVS_OP_READ0  = 3'h6,
      SNVS_OP_READ1  = 3'h7
   } snvs_op_t;

   typedef enum logic [3:0] {
      SNVS_D_PUR    = 4'h0,
      SNVS_D_IDLE   = 4'h1,
      SNVS_D_INSTR  = 4'h3,
      SNVS_D_WDATA  = 4'h2,
      SNVS_D_RDATA  = 4'h6,
      SNVS_D_DONE   = 4'h7,
      SNVS_D_STORE  = 4'h5,
      SNVS_D_RECALL = 4'h4
   } snvs_dstate_t;

   typedef enum logic [2:0] {
      SNVS_H_WAIT  = 3'h0,
      SNVS_H_IDLE  = 3'h1,
      SNVS_H_SETUP = 3'h3,
      SNVS_H_LOW   = 3'h2,
      SNVS_H_HIGH  = 3'h6,
      SNVS_H_DESEL = 3'h7
   } snvs_hstate_t;

endpackage : snvs_pkg

`default_nettype wire

/* File: include/snvs_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface snvs_if;
   logic ce;
   logic serial_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic store_n;
   logic recall_n;

   modport dev (
      input  ce,
      input  serial_clock,
      input  serial_in,
      input  store_n,
      input  recall_n,
      output serial_out,
      output serial_out_oe
   );

   modport hst (
      output ce,
      output serial_clock,
      output serial_in,
      output store_n,
      output recall_n,
      input  serial_out,
      input  serial_out_oe
   );
endinterface : snvs_if

`default_nettype wire

/* File: logic/snvs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module snvs_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // meta_r is read by q and nothing else
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : snvs_sync

`default_nettype wire

/* File: logic/snvs_device.sv */
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "snvs_params.svh"

module snvs_device
   import snvs_pkg::*;
#(
   parameter int unsigned STORE_CYCLES = `SNVS_STORE_CYC
) (
   // clock and reset
   input  wire logic MCLK,
   input  wire logic RST,
   // serial link
   snvs_if.dev       LINK,
   // status
   output logic      STORE_BUSY,
   output logic      RECALL_BUSY,
   output logic      WRITE_EN,
   output logic      RECALL_DONE,
   output logic      STANDBY
);
   localparam logic [`SNVS_TMR_W-1:0] TMR_STORE  = `SNVS_TMR_W'(STORE_CYCLES);
   localparam logic [`SNVS_TMR_W-1:0] TMR_RECALL = `SNVS_TMR_W'(`SNVS_RECALL_CYC);
   localparam logic [`SNVS_TMR_W-1:0] TMR_PUR    = `SNVS_TMR_W'(`SNVS_PUR_CYC);
   localparam logic [`SNVS_TMR_W-1:0] TMR_LAST   = `SNVS_TMR_W'(1);

   logic [4:0]              pins_s;
   logic                    ce;
   logic                    sclk;
   logic                    din;
   logic                    commit_n;
   logic                    reload_n;
   logic                    sclk_d_r;
   logic                    sclk_rise;
   logic                    sclk_fall;
   snvs_dstate_t            state_r;
   logic [`SNVS_TMR_W-1:0]  tmr_r;
   logic [7:0]              ir_r;
   logic [3:0]              cnt_r;
   logic [7:0]              full_byte;
   snvs_op_t                op;
   logic                    busy;
   logic                    byte_done;
   logic                    store_go;
   logic                    recall_go;
   logic                    tmr_end;
   logic                    wel_r;
   logic                    prl_r;
   logic [3:0]              addr_r;
   logic [15:0]             wsr_r;
   logic [4:0]              wcnt_r;
   logic [15:0]             rsr_r;
   logic [3:0]              rcnt_r;
   logic                    rd_on_r;
   logic                    wr_commit;
   logic [15:0][15:0]       ram_r;
   logic [15:0][15:0]       nv_r;

   // every pin comes from the host's domain
   snvs_sync #(
      .WIDTH (5)
   ) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   ({LINK.ce, LINK.serial_clock, LINK.serial_in, LINK.store_n, LINK.recall_n}),
      .q   (pins_s)
   );

   assign ce       = pins_s[4];
   assign sclk     = pins_s[3];
   assign din      = pins_s[2];
   assign commit_n = pins_s[1];
   assign reload_n = pins_s[0];

   // edges only, so a halted serial clock just holds everything
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk;
      end
   end

   assign sclk_rise = sclk & ~sclk_d_r;
   assign sclk_fall = ~sclk & sclk_d_r;
   assign full_byte = {ir_r[6:0], din};
   assign op        = snvs_op_t'(full_byte[`SNVS_OP_MSB:0]);
   // power-up recall is busy too, so commands die here
   assign busy      = (state_r == SNVS_D_PUR) || (state_r == SNVS_D_STORE) ||
                      (state_r == SNVS_D_RECALL);
   assign byte_done = (state_r == SNVS_D_INSTR) && ce && sclk_rise && (cnt_r == 4'h7);
   assign store_go  = !busy && wel_r && prl_r &&
                      ((byte_done && op == SNVS_OP_COMMIT) || !commit_n);
   assign recall_go = !busy && !store_go &&
                      ((byte_done && op == SNVS_OP_RELOAD) || !reload_n);
   assign tmr_end   = (tmr_r == TMR_LAST);
   assign wr_commit = (state_r == SNVS_D_WDATA) && !ce && (wcnt_r != 5'h0) &&
                      wel_r;

   // sequencing
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_r <= SNVS_D_PUR;
         tmr_r   <= TMR_PUR;
      end else begin
         case (state_r)
            SNVS_D_PUR, SNVS_D_STORE, SNVS_D_RECALL: begin
               // finishing in done forces a deselect before the next command
               if (tmr_end) begin
                  state_r <= SNVS_D_DONE;
               end else begin
                  tmr_r <= tmr_r - TMR_LAST;
               end
            end
            default: begin
               if (store_go) begin
                  state_r <= SNVS_D_STORE;
                  tmr_r   <= TMR_STORE;
               end else if (recall_go) begin
                  state_r <= SNVS_D_RECALL;
                  tmr_r   <= TMR_RECALL;
               end else if (!ce) begin
                  state_r <= SNVS_D_IDLE;
               end else begin
                  case (state_r)
                     SNVS_D_IDLE: begin
                        if (sclk_rise && din) begin
                           state_r <= SNVS_D_INSTR;
                        end
                     end
                     SNVS_D_INSTR: begin
                        if (byte_done) begin
                           case (op)
                              SNVS_OP_WRITE: state_r <= SNVS_D_WDATA;
                              SNVS_OP_READ0,
                              SNVS_OP_READ1: state_r <= SNVS_D_RDATA;
                              default:       state_r <= SNVS_D_DONE;
                           endcase
                        end
                     end
                     SNVS_D_RDATA: begin
                        if (sclk_rise && rd_on_r && rcnt_r == 4'hf) begin
                           state_r <= SNVS_D_DONE;
                        end
                     end
                     default: begin
                        state_r <= state_r;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // instruction register
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ir_r  <= 8'h00;
         cnt_r <= 4'h0;
      end else if (!ce) begin
         ir_r  <= 8'h00;
         cnt_r <= 4'h0;
      end else if (state_r == SNVS_D_IDLE && sclk_rise && din && !store_go && !recall_go) begin
         ir_r  <= 8'h01;
         cnt_r <= 4'h1;
      end else if (state_r == SNVS_D_INSTR && sclk_rise) begin
         ir_r  <= full_byte;
         cnt_r <= 4'(cnt_r + 4'h1);
      end
   end

   // write-enable and previous-recall latches
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         wel_r <= `SNVS_WEL_RST;
         prl_r <= `SNVS_PRL_RST;
      end else begin
         if (byte_done && op == SNVS_OP_WRDIS) begin
            wel_r <= 1'b0;
         end else if (byte_done && op == SNVS_OP_WRSET) begin
            wel_r <= 1'b1;
         end
         if (state_r == SNVS_D_STORE && tmr_end) begin
            wel_r <= 1'b0;
         end
         // the power-up recall ends in the same way but leaves prl alone
         if (state_r == SNVS_D_RECALL && tmr_end) begin
            prl_r <= 1'b1;
         end
      end
   end

   // serial data in and out
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         addr_r  <= 4'h0;
         wsr_r   <= 16'h0000;
         wcnt_r  <= 5'h00;
         rsr_r   <= 16'h0000;
         rcnt_r  <= 4'h0;
         rd_on_r <= 1'b0;
      end else begin
         if (byte_done) begin
            addr_r <= full_byte[`SNVS_ADR_MSB:`SNVS_ADR_LSB];
            wcnt_r <= 5'h00;
            rcnt_r <= 4'h0;
         end
         if (state_r == SNVS_D_WDATA && ce && sclk_rise) begin
            // no stop after 16: later bits push older ones out
            wsr_r <= {wsr_r[14:0], din};
            if (wcnt_r != 5'h10) begin
               wcnt_r <= 5'(wcnt_r + 5'h01);
            end
         end
         if (state_r == SNVS_D_RDATA && ce) begin
            if (sclk_fall && !rd_on_r) begin
               rsr_r   <= ram_r[addr_r];
               rd_on_r <= 1'b1;
            end else if (sclk_rise && rd_on_r && rcnt_r != 4'hf) begin
               rsr_r  <= {rsr_r[14:0], 1'b0};
               rcnt_r <= 4'(rcnt_r + 4'h1);
            end
         end else begin
            rd_on_r <= 1'b0;
         end
      end
   end

   // volatile array; reload copies every word in one edge
   always_ff @(posedge MCLK) begin
      if ((state_r == SNVS_D_RECALL || state_r == SNVS_D_PUR) && tmr_end) begin
         ram_r <= nv_r;
      end else if (wr_commit) begin
         ram_r[addr_r] <= wsr_r;
      end
   end

   // shadow array, blank after reset so simulation starts defined
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         nv_r <= '0;
      end else if (state_r == SNVS_D_STORE && tmr_end) begin
         nv_r <= ram_r;
      end
   end

   assign LINK.serial_out    = rsr_r[15];
   assign LINK.serial_out_oe = rd_on_r;
   assign STORE_BUSY         = (state_r == SNVS_D_STORE);
   assign RECALL_BUSY        = (state_r == SNVS_D_RECALL) || (state_r == SNVS_D_PUR);
   assign WRITE_EN           = wel_r;
   assign RECALL_DONE        = prl_r;
   assign STANDBY            = (state_r == SNVS_D_IDLE) && !ce;
endmodule : snvs_device

`default_nettype wire

/* File: logic/snvs_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "snvs_params.svh"

module snvs_host
   import snvs_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // serial link
   snvs_if.hst              LINK
);
   localparam logic [`SNVS_TMR_W-1:0] HALF = `SNVS_TMR_W'(`SNVS_SCLK_HALF_CYC);
   localparam logic [`SNVS_TMR_W-1:0] ONE  = `SNVS_TMR_W'(1);

   snvs_hstate_t           state_r;
   logic [`SNVS_TMR_W-1:0] div_r;
   logic [23:0]            sr_r;
   logic [4:0]             bcnt_r;
   logic [4:0]             nbits_r;
   logic                   rd_op_r;
   logic [15:0]            wdat_r;
   logic [15:0]            rword_r;
   logic [1:0]             pins_r;
   logic                   ce_r;
   logic                   sclk_r;
   logic                   do_s;
   logic                   start;
   logic                   div_end;

   snvs_sync #(
      .WIDTH (1)
   ) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   (LINK.serial_out),
      .q   (do_s)
   );

   assign start   = WR && ADDR == `SNVS_REG_CMD && state_r == SNVS_H_IDLE;
   assign div_end = (div_r == ONE);

   // host waits out the power-up recall, then runs one transfer per command
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_r <= SNVS_H_WAIT;
         div_r   <= `SNVS_TMR_W'(`SNVS_PUR_WAIT_CYC);
         ce_r    <= 1'b0;
         sclk_r  <= 1'b0;
         bcnt_r  <= 5'h00;
      end else begin
         if (!div_end) begin
            div_r <= div_r - ONE;
         end
         case (state_r)
            SNVS_H_WAIT: begin
               if (div_end) begin
                  state_r <= SNVS_H_IDLE;
               end
            end
            SNVS_H_IDLE: begin
               if (start) begin
                  state_r <= SNVS_H_SETUP;
                  ce_r    <= 1'b1;
                  div_r   <= HALF;
                  bcnt_r  <= 5'h00;
               end
            end
            SNVS_H_SETUP, SNVS_H_LOW: begin
               if (div_end) begin
                  state_r <= (state_r == SNVS_H_SETUP) ? SNVS_H_LOW : SNVS_H_HIGH;
                  sclk_r  <= (state_r == SNVS_H_LOW);
                  div_r   <= HALF;
               end
            end
            SNVS_H_HIGH: begin
               if (div_end) begin
                  sclk_r <= 1'b0;
                  div_r  <= HALF;
                  bcnt_r <= 5'(bcnt_r + 5'h01);
                  // drop enable before the next rising edge
                  state_r <= (5'(bcnt_r + 5'h01) == nbits_r) ? SNVS_H_DESEL
                                                             : SNVS_H_LOW;
               end
            end
            SNVS_H_DESEL: begin
               ce_r <= 1'b0;
               if (div_end) begin
                  state_r <= SNVS_H_IDLE;
               end
            end
            default: begin
               state_r <= SNVS_H_IDLE;
            end
         endcase
      end
   end

   // outgoing bits and incoming read word
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sr_r    <= 24'h000000;
         nbits_r <= 5'h08;
         rd_op_r <= 1'b0;
         rword_r <= 16'h0000;
      end else if (start) begin
         rd_op_r <= (WDATA[2:1] == 2'h3);
         nbits_r <= (WDATA[2:1] == 2'h3 || WDATA[2:0] == 3'h3) ? 5'h18 : 5'h08;
         // a read sends zeros after the instruction
         sr_r    <= {WDATA[7:0], (WDATA[2:1] == 2'h3) ? 16'h0000 : wdat_r};
      end else if (state_r == SNVS_H_HIGH && div_end) begin
         sr_r <= {sr_r[22:0], 1'b0};
      end else if (state_r == SNVS_H_LOW && div_end && rd_op_r && bcnt_r >= 5'h08) begin
         rword_r <= {rword_r[14:0], do_s};
      end
   end

   // software registers
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         wdat_r <= 16'h0000;
         pins_r <= 2'b00;
         RDATA  <= 32'h0000_0000;
      end else begin
         if (WR && ADDR == `SNVS_REG_WDATA) begin
            wdat_r <= WDATA[15:0];
         end
         if (WR && ADDR == `SNVS_REG_PINS) begin
            pins_r <= WDATA[1:0];
         end
         RDATA <= 32'h0000_0000;
         if (RD) begin
            case (ADDR)
               `SNVS_REG_WDATA: RDATA <= {16'h0000, wdat_r};
               `SNVS_REG_RDATA: RDATA <= {16'h0000, rword_r};
               `SNVS_REG_STAT:  RDATA <= {30'h0, state_r == SNVS_H_WAIT,
                                          state_r != SNVS_H_IDLE};
               `SNVS_REG_PINS:  RDATA <= {30'h0, pins_r};
               default:         RDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign LINK.ce           = ce_r;
   assign LINK.serial_clock = sclk_r;
   assign LINK.serial_in    = sr_r[23];
   assign LINK.store_n      = ~pins_r[`SNVS_PINS_STORE];
   assign LINK.recall_n     = ~pins_r[`SNVS_PINS_RECALL];
endmodule : snvs_host

`default_nettype wire

/* File: testbench/snvs_link_props.sv */
`timescale 1ns/1ps
`default_nettype none

module snvs_link_props #(
   parameter int unsigned STORE_CYCLES = 625000
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // link
   input wire logic ce,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic store_n,
   input wire logic recall_n,
   // device status
   input wire logic STORE_BUSY,
   input wire logic RECALL_BUSY,
   input wire logic WRITE_EN,
   input wire logic RECALL_DONE
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   logic        pur_r;
   logic [20:0] st_cnt_r;

   // first recall after reset is the power-up one
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) pur_r <= 1'b1;
      else if (!RECALL_BUSY) pur_r <= 1'b0;
   end

   // a counter, since the store length is far beyond any delay range
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) st_cnt_r <= '0;
      else if (STORE_BUSY) st_cnt_r <= st_cnt_r + 21'h1;
      else st_cnt_r <= '0;
   end

   property p_oe_ce;
      (!ce) [*8] |-> !serial_out_oe;
   endproperty
   a_oe_ce: assert property (p_oe_ce)
      else $error("data output driven while deselected");

   property p_quiet;
      (STORE_BUSY || RECALL_BUSY) [*8] |-> !serial_out_oe;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("data output driven during an array cycle");

   property p_store_needs;
      $rose(STORE_BUSY) |-> $past(WRITE_EN) && $past(RECALL_DONE);
   endproperty
   a_store_needs: assert property (p_store_needs)
      else $error("store started without both latches");

   property p_store_clears_wel;
      $fell(STORE_BUSY) |-> ##[0:2] !WRITE_EN;
   endproperty
   a_store_clears_wel: assert property (p_store_clears_wel)
      else $error("write enable left set after store");

   property p_store_len;
      STORE_BUSY |-> st_cnt_r <= 21'(STORE_CYCLES + 2);
   endproperty
   a_store_len: assert property (p_store_len)
      else $error("store runs too long");

   property p_recall_len;
      $rose(RECALL_BUSY) |-> ##[1:260] !RECALL_BUSY;
   endproperty
   a_recall_len: assert property (p_recall_len)
      else $error("recall runs too long");

   property p_recall_sets;
      !pur_r && $fell(RECALL_BUSY) |-> ##[0:2] RECALL_DONE;
   endproperty
   a_recall_sets: assert property (p_recall_sets)
      else $error("recall did not set the recall latch");

   property p_pur_no_latch;
      pur_r && $fell(RECALL_BUSY) |-> !RECALL_DONE;
   endproperty
   a_pur_no_latch: assert property (p_pur_no_latch)
      else $error("power-up recall set the recall latch");

   property p_pur_ignore;
      pur_r |-> !WRITE_EN && !serial_out_oe;
   endproperty
   a_pur_ignore: assert property (p_pur_ignore)
      else $error("activity during power-up recall");

   // pin requests pass two sync flops before the device acts
   property p_pin_store;
      $fell(store_n) && WRITE_EN && RECALL_DONE && !STORE_BUSY && !RECALL_BUSY |->
         ##[1:6] STORE_BUSY;
   endproperty
   a_pin_store: assert property (p_pin_store)
      else $error("store pin did not start a store");

   property p_pin_recall;
      $fell(recall_n) && store_n && !STORE_BUSY && !RECALL_BUSY |-> ##[1:6] RECALL_BUSY;
   endproperty
   a_pin_recall: assert property (p_pin_recall)
      else $error("recall pin did not start a recall");

   c_store: cover property ($fell(STORE_BUSY));
   c_recall: cover property (!pur_r && $fell(RECALL_BUSY));
   c_read: cover property ($fell(serial_out_oe));
endmodule : snvs_link_props

`default_nettype wire

/* File: testbench/serial_nv_sram_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "snvs_params.svh"

module serial_nv_sram_core_tb
   import snvs_pkg::*;
;
   localparam int unsigned STORE_CYC = 200;
   logic        mclk = 1'b0;
   logic        rst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        store_busy, recall_busy, write_en, recall_done, standby;
   int          fails;
   int          n_checks;
   logic [23:0] wire_bits = 24'h0;
   logic        sclk_d    = 1'b0;

   snvs_if link_if ();

   snvs_device #(.STORE_CYCLES(STORE_CYC)) snvs_device_inst (
      .MCLK(mclk), .RST(rst), .LINK(link_if.dev), .STORE_BUSY(store_busy),
      .RECALL_BUSY(recall_busy), .WRITE_EN(write_en), .RECALL_DONE(recall_done),
      .STANDBY(standby));

   snvs_host snvs_host_inst (
      .MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .LINK(link_if.hst));

   snvs_link_props #(.STORE_CYCLES(STORE_CYC)) snvs_link_props_inst (
      .MCLK(mclk), .RST(rst), .ce(link_if.ce), .serial_clock(link_if.serial_clock),
      .serial_in(link_if.serial_in), .serial_out(link_if.serial_out),
      .serial_out_oe(link_if.serial_out_oe), .store_n(link_if.store_n),
      .recall_n(link_if.recall_n), .STORE_BUSY(store_busy), .RECALL_BUSY(recall_busy),
      .WRITE_EN(write_en), .RECALL_DONE(recall_done));

   always #4 mclk = ~mclk;

   // bits seen on the wire at each serial clock rise
   always @(posedge mclk) begin
      sclk_d <= link_if.serial_clock;
      if (link_if.ce && link_if.serial_clock && !sclk_d)
         wire_bits <= {wire_bits[22:0], link_if.serial_in};
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge mclk);
   endtask : rd_reg

   task automatic wait_idle();
      logic [31:0] s;
      s = 32'h3;
      for (int i = 0; i < 600 && s[1:0] != 2'h0; i++) rd_reg(`SNVS_REG_STAT, s);
      chk("host_idle", 32'h0, {30'h0, s[1:0]});
   endtask : wait_idle

   task automatic pulse_wait(const ref logic s, input string what);
      int i;
      i = 0;
      while (s !== 1'b1 && i < 100) begin @(posedge mclk); i++; end
      chk({what, "_start"}, 32'h1, {31'h0, s});
      while (s !== 1'b0 && i < 3000) begin @(posedge mclk); i++; end
      chk({what, "_end"}, 32'h0, {31'h0, s});
   endtask : pulse_wait

   function automatic logic [7:0] ins(input snvs_op_t op, input logic [3:0] a);
      return {1'b1, a, op};
   endfunction : ins

   task automatic cmd(input logic [7:0] i, input logic [15:0] d);
      wr_reg(`SNVS_REG_WDATA, {16'h0, d});
      wr_reg(`SNVS_REG_CMD, {24'h0, i});
      wait_idle();
   endtask : cmd

   task automatic rdw(input snvs_op_t op, input logic [3:0] a, input logic [15:0] exp);
      logic [31:0] d;
      cmd(ins(op, a), 16'h0);
      rd_reg(`SNVS_REG_RDATA, d);
      chk("ram_word", {16'h0, exp}, d);
   endtask : rdw

   initial begin
      logic [31:0] d;
      rst = 1'b1; addr = 8'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
      fails = 0; n_checks = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd_reg(`SNVS_REG_STAT, d);
      chk("pur_wait", 32'h2, d & 32'h2);
      chk("wel_pur", 32'h0, {31'h0, write_en});
      chk("prl_pur", 32'h0, {31'h0, recall_done});
      wait_idle();
      rdw(SNVS_OP_READ0, 4'h3, 16'h0);
      rd_reg(8'h20, d);
      chk("unmapped", 32'h0, d);
      $display("test power_up done");
      cmd(ins(SNVS_OP_WRITE, 4'h5), 16'ha5a5);
      rdw(SNVS_OP_READ0, 4'h5, 16'h0);
      cmd(ins(SNVS_OP_WRSET, 4'h0), 16'h0);
      chk("wel_set", 32'h1, {31'h0, write_en});
      cmd(ins(SNVS_OP_WRITE, 4'h5), 16'h1234);
      chk("wire_bits", {8'h0, ins(SNVS_OP_WRITE, 4'h5), 16'h1234}, {8'h0, wire_bits});
      chk("link_idle", 32'h0, {30'h0, link_if.ce, link_if.serial_clock});
      repeat (8) @(posedge mclk);
      chk("standby", 32'h1, {31'h0, standby});
      cmd(ins(SNVS_OP_WRITE, 4'hf), 16'hbeef);
      rdw(SNVS_OP_READ0, 4'h5, 16'h1234);
      rdw(SNVS_OP_READ1, 4'hf, 16'hbeef);
      $display("test write_read done");
      cmd(ins(SNVS_OP_RSVD, 4'h5), 16'hffff);
      chk("wel_rsvd", 32'h1, {31'h0, write_en});
      rdw(SNVS_OP_READ0, 4'h5, 16'h1234);
      cmd(ins(SNVS_OP_COMMIT, 4'h0), 16'h0);
      repeat (50) @(posedge mclk);
      chk("store_blocked", 32'h0, {31'h0, store_busy});
      $display("test inhibits done");
      cmd(ins(SNVS_OP_RELOAD, 4'h0), 16'h0);
      pulse_wait(recall_busy, "sw_recall");
      chk("prl_set", 32'h1, {31'h0, recall_done});
      rdw(SNVS_OP_READ0, 4'h5, 16'h0);
      cmd(ins(SNVS_OP_WRITE, 4'h5), 16'hc3c3);
      cmd(ins(SNVS_OP_COMMIT, 4'h0), 16'h0);
      pulse_wait(store_busy, "sw_store");
      chk("wel_after_store", 32'h0, {31'h0, write_en});
      cmd(ins(SNVS_OP_WRSET, 4'h0), 16'h0);
      cmd(ins(SNVS_OP_WRITE, 4'h5), 16'h0);
      wr_reg(`SNVS_REG_PINS, 32'h2);
      pulse_wait(recall_busy, "pin_recall");
      wr_reg(`SNVS_REG_PINS, 32'h0);
      repeat (300) @(posedge mclk);
      rdw(SNVS_OP_READ1, 4'h5, 16'hc3c3);
      $display("test store_recall done");
      cmd(ins(SNVS_OP_WRDIS, 4'h0), 16'h0);
      chk("wel_clear", 32'h0, {31'h0, write_en});
      cmd(ins(SNVS_OP_WRSET, 4'h0), 16'h0);
      wr_reg(`SNVS_REG_PINS, 32'h1);
      pulse_wait(store_busy, "pin_store");
      wr_reg(`SNVS_REG_PINS, 32'h0);
      chk("wel_pin_store", 32'h0, {31'h0, write_en});
      $display("test pins done");
      stop_test();
   end

   // the tests need some 9k cycles; this allows 50k
   initial begin
      #400000;
      fails++;
      stop_test();
   end
endmodule : serial_nv_sram_core_tb

`default_nettype wire
